// ### fawc_pkg.sv
// shared constants and carriers for the flash access wait control block
// assumes a single 100 MHz cpu clock and a synchronous active-high reset
package fawc_pkg;

    // =========================================================
    // widths
    localparam int ADDR_W = 24;
    localparam int DATA_W = 16;
    localparam int WS_W   = 2;
    localparam int TMR_W  = 26;

    // =========================================================
    // timing: figures as printed, cycles derived from the clock rate
    localparam int CLK_MHZ         = 100;
    localparam int PROG_TIME_MS    = 5;    // longest block programming time
    localparam int ERASE_TIME_MS   = 500;  // longest sector erase time
    localparam int US_PER_MS       = 1000;
    localparam logic [TMR_W-1:0] PROG_CYCLES  =
        TMR_W'(PROG_TIME_MS * US_PER_MS * CLK_MHZ);
    localparam logic [TMR_W-1:0] ERASE_CYCLES =
        TMR_W'(ERASE_TIME_MS * US_PER_MS * CLK_MHZ);

    // =========================================================
    // programming block geometry: 128 bytes per block
    localparam int BLOCK_BITS = 7;
    localparam logic [BLOCK_BITS-1:0] BLOCK_ZERO = 7'h00;

    // =========================================================
    // reset values
    localparam logic [WS_W-1:0]   WS_ZERO   = 2'h0;
    localparam logic [DATA_W-1:0] DATA_ZERO = 16'h0000;
    localparam logic [ADDR_W-1:0] ADDR_ZERO = 24'h000000;
    localparam logic [TMR_W-1:0]  TMR_ZERO  = 26'h0000000;
    localparam logic [TMR_W-1:0]  TMR_ONE   = 26'h0000001;

    // =========================================================
    // read request from the fetch / data requester
    typedef struct packed {
        logic              valid;
        logic              seq;    // sequential, served from prefetch
        logic [ADDR_W-1:0] addr;
    } fawc_rd_req_s;

    // program / erase request
    typedef struct packed {
        logic              valid;
        logic              erase;  // 1: sector erase, 0: block program
        logic [ADDR_W-1:0] addr;
    } fawc_op_req_s;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_ACCESS,
        ST_OP
    } fawc_state_e;

endpackage

// ### fawc_op_timer.sv
// down counter timing one program or erase operation
// assumes start is a one-cycle pulse given only while not busy
module fawc_op_timer
    import fawc_pkg::*;
(
    input  wire logic             clock,
    input  wire logic             srst,
    input  wire logic             start,
    input  wire logic [TMR_W-1:0] load,
    output logic                  busy_q,
    output logic                  done_q
);

    logic [TMR_W-1:0] cnt_q;
    wire              last = busy_q && (cnt_q == TMR_ONE);

    // =========================================================
    // busy for exactly load cycles after the start edge
    always_ff @(posedge clock) begin
        if (srst) begin
            cnt_q  <= TMR_ZERO;
            busy_q <= 1'b0;
            done_q <= 1'b0;
        end else begin
            done_q <= last;
            if (start) begin
                cnt_q  <= load;
                busy_q <= 1'b1;
            end else if (busy_q) begin
                cnt_q  <= cnt_q - TMR_ONE;
                busy_q <= !last;
            end
        end
    end

endmodule // fawc_op_timer

// ### fawc_flash_access_wait_control.sv
// wait-state sequencer for reads from the on-chip flash array,
// plus timing of block programming and sector erase
// assumes the flash array answers within its access time of the address,
// and that the wait field comes from the memory bus control register
module fawc_flash_access_wait_control
    import fawc_pkg::*;
#(
    parameter logic [TMR_W-1:0] PROG_CYC  = PROG_CYCLES,
    parameter logic [TMR_W-1:0] ERASE_CYC = ERASE_CYCLES
)
(
    input  wire logic                 clock,
    input  wire logic                 srst,
    input  wire logic [WS_W-1:0]      flash_wait_count,
    input  wire fawc_rd_req_s         rd_req,
    input  wire fawc_op_req_s         op_req,
    input  wire logic [DATA_W-1:0]    array_rdata,
    output logic                      ready_q,
    output logic                      rvalid_q,
    output logic [DATA_W-1:0]         rdata_q,
    output logic [ADDR_W-1:0]         array_addr_q,
    output logic [ADDR_W-1:0]         op_addr_q,
    output logic                      op_erase_q,
    output logic                      op_busy_q,
    output logic                      op_done_q
);

    fawc_state_e      state_q;
    fawc_state_e      state_d;
    logic [WS_W-1:0]  wait_q;
    logic [TMR_W-1:0] elapsed_q;

    // =========================================================
    // request decode; reads win over a program or erase start
    wire rd_take  = rd_req.valid && ready_q;
    wire op_take  = op_req.valid && ready_q && !rd_req.valid;
    wire wait_end = (state_q == ST_ACCESS) && (wait_q == WS_ZERO);
    // sequential fetches come from prefetch, so no wait states
    wire [WS_W-1:0] wait_load = rd_req.seq ? WS_ZERO : flash_wait_count;
    // programming works on whole blocks, low address bits dropped
    wire [ADDR_W-1:0] op_addr_aln = op_req.erase ? op_req.addr :
        {op_req.addr[ADDR_W-1:BLOCK_BITS], BLOCK_ZERO};
    wire [TMR_W-1:0] op_load = op_req.erase ? ERASE_CYC : PROG_CYC;

    // =========================================================
    // next state
    always_comb begin
        state_d = state_q;
        case (state_q)
            ST_IDLE: begin
                if (rd_take) begin
                    state_d = ST_ACCESS;
                end else if (op_take) begin
                    state_d = ST_OP;
                end
            end
            ST_ACCESS: begin
                if (wait_end) begin
                    state_d = ST_IDLE;
                end
            end
            ST_OP: begin
                if (op_done_q) begin
                    state_d = ST_IDLE;
                end
            end
            default: state_d = ST_IDLE;
        endcase
    end

    // =========================================================
    // state, handshake and wait counter
    always_ff @(posedge clock) begin
        if (srst) begin
            state_q <= ST_IDLE;
            ready_q <= 1'b1;
            wait_q  <= WS_ZERO;
        end else begin
            state_q <= state_d;
            ready_q <= (state_d == ST_IDLE); // stalled while waits run
            if (rd_take) begin
                wait_q <= wait_load;
            end else if (state_q == ST_ACCESS && !wait_end) begin
                wait_q <= wait_q - 2'h1;
            end
        end
    end

    // =========================================================
    // read path: data captured only in the last access cycle
    always_ff @(posedge clock) begin
        if (srst) begin
            rvalid_q     <= 1'b0;
            rdata_q      <= DATA_ZERO;
            array_addr_q <= ADDR_ZERO;
        end else begin
            rvalid_q <= wait_end;
            if (wait_end) begin
                rdata_q <= array_rdata;
            end
            if (rd_take) begin
                array_addr_q <= rd_req.addr;
            end
        end
    end

    // =========================================================
    // program / erase bookkeeping
    always_ff @(posedge clock) begin
        if (srst) begin
            op_addr_q  <= ADDR_ZERO;
            op_erase_q <= 1'b0;
            elapsed_q  <= TMR_ZERO;
        end else begin
            if (op_take) begin
                op_addr_q  <= op_addr_aln;
                op_erase_q <= op_req.erase;
                elapsed_q  <= TMR_ZERO;
            end else if (op_busy_q) begin
                elapsed_q <= elapsed_q + TMR_ONE;
            end
        end
    end

    // one shared timer: program and erase never overlap
    fawc_op_timer u_timer (
        .clock  (clock),
        .srst   (srst),
        .start  (op_take),
        .load   (op_load),
        .busy_q (op_busy_q),
        .done_q (op_done_q)
    );

    // =========================================================
    // checks
    logic [WS_W:0]   acc_len_q;
    logic [WS_W-1:0] ws_seen_q;
    always_ff @(posedge clock) begin
        if (srst) begin
            acc_len_q <= 3'h0;
            ws_seen_q <= WS_ZERO;
        end else if (rd_take) begin
            acc_len_q <= 3'h1;
            ws_seen_q <= wait_load;
        end else if (state_q == ST_ACCESS && !wait_end) begin
            acc_len_q <= acc_len_q + 3'h1;
        end
    end

    access_length_a: assert property (
        @(posedge clock) disable iff (srst)
        $rose(rvalid_q) |-> acc_len_q == {1'b0, ws_seen_q} + 3'h1)
        else $error("access length not one plus wait states");

    wait_field_a: assert property (
        @(posedge clock) disable iff (srst)
        rd_take && !rd_req.seq |=> wait_q == $past(flash_wait_count))
        else $error("wait count not taken from control field");

    seq_nowait_a: assert property (
        @(posedge clock) disable iff (srst)
        rd_take && rd_req.seq |=> ##1 rvalid_q)
        else $error("sequential access got wait states");

    stall_hold_a: assert property (
        @(posedge clock) disable iff (srst)
        state_q == ST_ACCESS && !wait_end |=> !ready_q && !rvalid_q)
        else $error("requester not stalled during access");

    data_final_a: assert property (
        @(posedge clock) disable iff (srst)
        rvalid_q |-> rdata_q == $past(array_rdata) && $past(state_q) == ST_ACCESS)
        else $error("read data not from final access cycle");

    prog_time_a: assert property (
        @(posedge clock) disable iff (srst)
        op_done_q && !op_erase_q |-> elapsed_q == PROG_CYC)
        else $error("block program time wrong");

    block_align_a: assert property (
        @(posedge clock) disable iff (srst)
        op_busy_q && !op_erase_q |-> op_addr_q[BLOCK_BITS-1:0] == BLOCK_ZERO)
        else $error("program address not block aligned");

    erase_time_a: assert property (
        @(posedge clock) disable iff (srst)
        op_done_q && op_erase_q |-> elapsed_q == ERASE_CYC)
        else $error("sector erase time wrong");

    cov_wait_read_c: cover property (
        @(posedge clock) disable iff (srst)
        rd_take && !rd_req.seq && flash_wait_count != WS_ZERO ##[1:5] rvalid_q);
    cov_seq_read_c: cover property (
        @(posedge clock) disable iff (srst) rd_take && rd_req.seq);
    cov_prog_done_c: cover property (
        @(posedge clock) disable iff (srst) op_done_q && !op_erase_q);
    cov_erase_done_c: cover property (
        @(posedge clock) disable iff (srst) op_done_q && op_erase_q);

endmodule // fawc_flash_access_wait_control

// ### fawc_array_model.sv
// flash array model standing behind the wait-state sequencer
// assumes the sequencer holds the address for the whole access phase
module fawc_array_model
    import fawc_pkg::*;
(
    input  wire logic [ADDR_W-1:0] addr,
    output logic      [DATA_W-1:0] rdata
);
    timeunit 1ns;
    timeprecision 1ps;

    // =========================================================
    // data path
    // pattern derived from the address, so a stale or wrong address shows
    // data is settled well inside one cycle, so any wait count is enough
    assign rdata = addr[DATA_W-1:0] ^ 16'hA5C3;
endmodule // fawc_array_model

// ### fawc_flash_access_wait_control_tb.sv
// self-checking bench for the flash access wait control block
// assumes 100 MHz clock, inputs driven on the falling edge, short op timers
module fawc_flash_access_wait_control_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import fawc_pkg::*;

    // =========================================================
    // shortened timer lengths keep the run small
    localparam logic [TMR_W-1:0] P_CYC = 26'h0000005;
    localparam logic [TMR_W-1:0] E_CYC = 26'h0000008;

    logic              clock;
    logic              srst;
    logic [WS_W-1:0]   flash_wait_count;
    fawc_rd_req_s      rd_req;
    fawc_op_req_s      op_req;
    logic [DATA_W-1:0] array_rdata;
    logic              ready_q;
    logic              rvalid_q;
    logic [DATA_W-1:0] rdata_q;
    logic [ADDR_W-1:0] array_addr_q;
    logic [ADDR_W-1:0] op_addr_q;
    logic              op_erase_q;
    logic              op_busy_q;
    logic              op_done_q;
    int                mismatches;
    int                n_tests;

    fawc_flash_access_wait_control #(
        .PROG_CYC  (P_CYC),
        .ERASE_CYC (E_CYC)
    ) u_fawc_flash_access_wait_control (
        .clock(clock), .srst(srst), .flash_wait_count(flash_wait_count),
        .rd_req(rd_req), .op_req(op_req), .array_rdata(array_rdata),
        .ready_q(ready_q), .rvalid_q(rvalid_q), .rdata_q(rdata_q),
        .array_addr_q(array_addr_q), .op_addr_q(op_addr_q), .op_erase_q(op_erase_q),
        .op_busy_q(op_busy_q), .op_done_q(op_done_q));

    fawc_array_model u_fawc_array_model (.addr(array_addr_q), .rdata(array_rdata));

    // =========================================================
    // clock
    always #5 clock = ~clock;

    // =========================================================
    // shared compare and closing report
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // cycle counts are bench-side integers, never unknown
    task automatic check_cycles(input int got, input int exp);
        n_tests++;
        if (got != exp) begin
            mismatches++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic print_verdict;
        $display("comparisons=%0d mismatches=%0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // =========================================================
    // one read: counts edges from take to data, checks stall and data
    task automatic do_read(input logic [WS_W-1:0] ws, input logic seq,
                           input logic [ADDR_W-1:0] addr);
        int n;
        int exp_n;
        exp_n = seq ? 1 : 1 + int'(ws);
        n = 0;
        @(negedge clock);
        flash_wait_count = ws;
        rd_req = '{valid: 1'b1, seq: seq, addr: addr};
        @(posedge clock);
        #1;
        check(ready_q, 1'b0);
        @(negedge clock);
        rd_req.valid = 1'b0;
        flash_wait_count = ~ws; // later field changes must not stretch this access
        while (n < 20 && rvalid_q !== 1'b1) begin
            @(posedge clock);
            #1;
            n++;
            if (rvalid_q !== 1'b1) check(ready_q, 1'b0);
        end
        if (n >= 20) begin
            mismatches++;
            print_verdict();
        end
        check_cycles(n, exp_n);
        check(rdata_q, addr[DATA_W-1:0] ^ 16'hA5C3);
        check(array_addr_q, addr);
        @(posedge clock);
        #1;
        check(rvalid_q, 1'b0);
        $display("read done ws=%0d seq=%0d cycles=%0d", ws, seq, n);
    endtask

    // =========================================================
    // one program or erase: duration, busy level and address alignment
    task automatic do_op(input logic erase, input logic [ADDR_W-1:0] addr,
                         input logic [TMR_W-1:0] cyc);
        int n;
        n = 0;
        @(negedge clock);
        op_req = '{valid: 1'b1, erase: erase, addr: addr};
        @(posedge clock);
        #1;
        check(op_busy_q, 1'b1);
        @(negedge clock);
        op_req.valid = 1'b0;
        while (n < 40 && op_done_q !== 1'b1) begin
            @(posedge clock);
            #1;
            n++;
            if (op_done_q !== 1'b1) check(ready_q, 1'b0);
        end
        if (n >= 40) begin
            mismatches++;
            print_verdict();
        end
        check_cycles(n, int'(cyc));
        check(op_busy_q, 1'b0);
        check(op_erase_q, erase);
        check(op_addr_q, erase ? addr : {addr[ADDR_W-1:BLOCK_BITS], BLOCK_ZERO});
        @(posedge clock);
        #1;
        check(ready_q, 1'b1);
        $display("op done erase=%0d cycles=%0d", erase, n);
    endtask

    // =========================================================
    // read and erase raised together: the read wins, the erase waits
    task automatic do_both(input logic [ADDR_W-1:0] addr);
        int n;
        n = 0;
        @(negedge clock);
        flash_wait_count = WS_ZERO;
        rd_req = '{valid: 1'b1, seq: 1'b0, addr: addr};
        op_req = '{valid: 1'b1, erase: 1'b1, addr: addr};
        @(posedge clock);
        #1;
        check(op_busy_q, 1'b0);
        @(negedge clock);
        rd_req.valid = 1'b0;
        @(posedge clock);
        #1;
        check(rvalid_q, 1'b1);
        check(rdata_q, addr[DATA_W-1:0] ^ 16'hA5C3);
        check(op_busy_q, 1'b0);
        // the held erase request is taken once ready is back
        @(posedge clock);
        #1;
        check(op_busy_q, 1'b1);
        @(negedge clock);
        op_req.valid = 1'b0;
        while (n < 40 && op_done_q !== 1'b1) begin
            @(posedge clock);
            #1;
            n++;
        end
        if (n >= 40) begin
            mismatches++;
            print_verdict();
        end
        check_cycles(n, int'(E_CYC));
        check(op_erase_q, 1'b1);
        @(posedge clock);
        #1;
        check(ready_q, 1'b1);
        $display("priority done cycles=%0d", n);
    endtask

    // =========================================================
    // main sequence
    initial begin
        clock = 1'b0;
        srst = 1'b1;
        flash_wait_count = WS_ZERO;
        rd_req = '0;
        op_req = '0;
        mismatches = 0;
        n_tests = 0;
        repeat (2) @(posedge clock);
        @(negedge clock);
        srst = 1'b0;
        check(ready_q, 1'b1);
        for (int w = 0; w < 4; w++) begin
            do_read(WS_W'(w), 1'b0, 24'h00A000 + ADDR_W'(w * 3));
        end
        do_read(2'h3, 1'b1, 24'h00B7F1);
        do_op(1'b0, 24'h12345F, P_CYC);
        do_op(1'b1, 24'h0456C3, E_CYC);
        do_both(24'h00C0D5);
        print_verdict();
    end
endmodule // fawc_flash_access_wait_control_tb
